// ### hw/ac_sense_pkg.sv
package ac_sense_pkg;
  // register offsets on the plain register port
  localparam logic [15:0] ADDR_GAIN_TRIM = 16'hfe77;
  localparam logic [15:0] ADDR_FLAG_CONFIG = 16'hfe78;
  localparam logic [15:0] ADDR_FLAG_STATUS = 16'hfe7f;
  localparam logic [15:0] ADDR_VALUE_HI = 16'hfed9;
  localparam logic [15:0] ADDR_VALUE_LO = 16'hfeda;

  localparam logic [7:0] GAIN_TRIM_RESET = 8'h00;
  localparam logic [7:0] FLAG_CONFIG_RESET = 8'h00;

  // field positions
  localparam int TRIM_SIGN_BIT = 7;
  localparam int CFG_INCLUDE_BIT = 7;
  localparam int CFG_PG_DEB_BIT = 6;
  localparam int CFG_THR_LSB = 2;
  localparam int CFG_DEB_LSB = 0;
  localparam int STAT_RAW_BIT = 0;
  localparam int STAT_FLAG_BIT = 1;
  localparam int STAT_PG_FLAG_BIT = 2;

  localparam int VALUE_W = 16;
  localparam int TRIM_SHIFT = 10;

  // timing: one debounce tick every 100 us
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int DEB_SHORT_US = 2600;
  localparam int DEB_MID_US = 10400;
  localparam int DEB_LONG_US = 100000;
  localparam int DEB_SHORT_TICKS = DEB_SHORT_US / TICK_US;
  localparam int DEB_MID_TICKS = DEB_MID_US / TICK_US;
  localparam int DEB_LONG_TICKS = DEB_LONG_US / TICK_US;
  localparam int DEB_CNT_W = 12;

  localparam int HYST_MV = 75;

  typedef enum logic [1:0] {DEB_NONE, DEB_SHORT, DEB_MID, DEB_LONG} deb_sel_e;

  typedef struct packed {
    logic negative;
    logic [6:0] magnitude;
  } gain_trim_s;

  typedef struct packed {
    logic includeInPg;
    logic pgDebounce;
    logic [3:0] threshold;
    deb_sel_e debounceSel;
  } flag_config_s;
endpackage : ac_sense_pkg

// ### hw/flag_debounce.sv
`timescale 1ns/10ps
module flag_debounce (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic rawIn,
  input wire logic [ac_sense_pkg::DEB_CNT_W-1:0] limit,
  output logic flagOut
);
  logic flag_q;
  logic [ac_sense_pkg::DEB_CNT_W-1:0] cnt_q;
  logic [ac_sense_pkg::DEB_CNT_W-1:0] cntInc;
  wire bypass = (limit == '0);
  wire differs = (rawIn != flag_q);
  wire expire = tick && ((cntInc >= limit));

  assign cntInc = cnt_q + 1'b1;
  assign flagOut = flag_q;

  // any reversal restarts the timer; tick granularity gives up to one tick of slack
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      cnt_q <= '0;
    end else if (bypass) begin
      flag_q <= rawIn;
      cnt_q <= '0;
    end else if (!differs) begin
      cnt_q <= '0;
    end else if (expire) begin
      flag_q <= rawIn;
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cntInc;
    end
  end

  a_deb_hold_early: assert property (@(posedge mclk) disable iff (!rst_n)
    (!bypass && differs && !expire) |=> $stable(flag_q))
    else $error("debounced flag changed before its time ran out");

  a_deb_restart: assert property (@(posedge mclk) disable iff (!rst_n)
    (!bypass && !differs) |=> (cnt_q == '0))
    else $error("debounce timer not restarted when raw agrees with flag");
endmodule : flag_debounce

// ### hw/ac_sense_flag_logic.sv
// Operation
// - trim register bit 7 high subtracts the correction, low adds it
// - trim bits 6..0 scale the ac sense reading as a gain correction
// - config bit 7 folds the ac sense flag into both power-good flags
// - config bit 6 picks the power-good path debounce: none or 2.6 ms
// - threshold bits 5..2 compare against the top four bits of the sense value
// - comparison has 75 mV hysteresis between asserting and releasing levels
// - threshold of zero keeps the ac sense flag cleared
// - config bits 1..0 pick flag debounce: none, 2.6, 10.4 or 100 ms
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
module ac_sense_flag_logic #(
  parameter int FULL_SCALE_MV = 1600,
  parameter int DEB_SHORT_TICKS = ac_sense_pkg::DEB_SHORT_TICKS,
  parameter int DEB_MID_TICKS = ac_sense_pkg::DEB_MID_TICKS,
  parameter int DEB_LONG_TICKS = ac_sense_pkg::DEB_LONG_TICKS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic [ac_sense_pkg::VALUE_W-1:0] acSample,
  input wire logic acSampleValid,
  input wire logic powerGoodRawA,
  input wire logic powerGoodRawB,
  output logic [ac_sense_pkg::VALUE_W-1:0] acSenseValue,
  output logic acSenseFlag,
  output logic power_good_chan_a,
  output logic power_good_chan_b
);
  localparam int VW = ac_sense_pkg::VALUE_W;
  localparam int HYST_CNT = ac_sense_pkg::HYST_MV * (2 ** VW) / FULL_SCALE_MV;
  localparam int CW = ac_sense_pkg::DEB_CNT_W;

  ac_sense_pkg::gain_trim_s trim_q;
  ac_sense_pkg::flag_config_s cfg_q;
  logic [VW-1:0] value_q;
  logic rawFlag_q;
  logic [7:0] rdata_q;
  logic pgA_q;
  logic pgB_q;
  logic [11:0] tickCnt_q;
  logic tick_q;
  logic flagDeb;
  logic pgFlagDeb;

  // register decode
  wire selTrim = (regAddr == ac_sense_pkg::ADDR_GAIN_TRIM);
  wire selCfg = (regAddr == ac_sense_pkg::ADDR_FLAG_CONFIG);
  wire selStat = (regAddr == ac_sense_pkg::ADDR_FLAG_STATUS);
  wire selHi = (regAddr == ac_sense_pkg::ADDR_VALUE_HI);
  wire selLo = (regAddr == ac_sense_pkg::ADDR_VALUE_LO);
  wire [7:0] statusWord = {5'h00, pgFlagDeb, flagDeb, rawFlag_q};
  wire [7:0] readMux = selTrim ? trim_q :
                       selCfg ? cfg_q :
                       selStat ? statusWord :
                       selHi ? value_q[VW-1:VW-8] :
                       selLo ? value_q[7:0] : 8'h00;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trim_q <= ac_sense_pkg::GAIN_TRIM_RESET;
      cfg_q <= ac_sense_pkg::FLAG_CONFIG_RESET;
      rdata_q <= 8'h00;
    end else begin
      if (regWrite && selTrim) trim_q <= regWdata;
      if (regWrite && selCfg) cfg_q <= regWdata;
      rdata_q <= regRead ? readMux : 8'h00;
    end
  end
  assign regRdata = rdata_q;

  // gain trim: correction = sample * magnitude / 1024, saturating on the high side
  wire [VW+6:0] trimProd = acSample * trim_q.magnitude;
  wire [VW:0] trimCorr = {4'h0, trimProd[VW+6:ac_sense_pkg::TRIM_SHIFT]};
  wire [VW:0] sumUp = {1'b0, acSample} + trimCorr;
  wire [VW:0] sumDown = {1'b0, acSample} - trimCorr;
  wire [VW-1:0] trimmed = trim_q.negative ? sumDown[VW-1:0] :
                          (sumUp[VW] ? {VW{1'b1}} : sumUp[VW-1:0]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) value_q <= '0;
    else if (acSampleValid) value_q <= trimmed;
  end
  assign acSenseValue = value_q;

  // threshold with hysteresis; flag set while the value sits under the threshold
  wire thrZero = (cfg_q.threshold == 4'h0);
  wire [VW:0] setLevel = {1'b0, cfg_q.threshold, {(VW-4){1'b0}}};
  wire [VW:0] relLevel = setLevel + (VW+1)'(HYST_CNT);
  wire belowSet = ({1'b0, value_q} < setLevel);
  wire belowRel = ({1'b0, value_q} < relLevel);
  wire rawFlag_d = thrZero ? 1'b0 : (rawFlag_q ? belowRel : belowSet);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rawFlag_q <= 1'b0;
    else rawFlag_q <= rawFlag_d;
  end

  // shared 100 us tick keeps the debounce counters narrow
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= 12'h000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tickCnt_q == 12'(ac_sense_pkg::TICK_CYC - 1));
      tickCnt_q <= (tickCnt_q == 12'(ac_sense_pkg::TICK_CYC - 1)) ? 12'h000 : tickCnt_q + 12'h001;
    end
  end

  wire [CW-1:0] flagLimit = (cfg_q.debounceSel == ac_sense_pkg::DEB_SHORT) ? CW'(DEB_SHORT_TICKS) :
                            (cfg_q.debounceSel == ac_sense_pkg::DEB_MID) ? CW'(DEB_MID_TICKS) :
                            (cfg_q.debounceSel == ac_sense_pkg::DEB_LONG) ? CW'(DEB_LONG_TICKS) :
                            '0;
  wire [CW-1:0] pgLimit = cfg_q.pgDebounce ? CW'(DEB_SHORT_TICKS) : '0;

  flag_debounce flagDebounce (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick_q),
    .rawIn(rawFlag_q),
    .limit(flagLimit),
    .flagOut(flagDeb)
  );

  // the power-good path carries its own debounce, independent of the flag's
  flag_debounce pgDebounce (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick_q),
    .rawIn(rawFlag_q),
    .limit(pgLimit),
    .flagOut(pgFlagDeb)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pgA_q <= 1'b0;
      pgB_q <= 1'b0;
    end else begin
      pgA_q <= powerGoodRawA && !(cfg_q.includeInPg && pgFlagDeb);
      pgB_q <= powerGoodRawB && !(cfg_q.includeInPg && pgFlagDeb);
    end
  end
  assign acSenseFlag = flagDeb;
  assign power_good_chan_a = pgA_q;
  assign power_good_chan_b = pgB_q;

  a_trim_negative_sign: assert property (@(posedge mclk) disable iff (!rst_n)
    (acSampleValid && trim_q.negative) |=> (value_q <= $past(acSample)))
    else $error("negative trim raised the sense value");

  a_trim_positive_sign: assert property (@(posedge mclk) disable iff (!rst_n)
    (acSampleValid && !trim_q.negative) |=> (value_q >= $past(acSample)))
    else $error("positive trim lowered the sense value");

  a_trim_zero_mag: assert property (@(posedge mclk) disable iff (!rst_n)
    (acSampleValid && trim_q.magnitude == 7'h00) |=> (value_q == $past(acSample)))
    else $error("zero trim magnitude changed the sense value");

  a_pg_fold_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_q.includeInPg |=> (power_good_chan_a == $past(powerGoodRawA)
                            && power_good_chan_b == $past(powerGoodRawB)))
    else $error("power-good changed while fold is off");

  a_pg_fold_on: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_q.includeInPg && pgFlagDeb) |=> (!power_good_chan_a && !power_good_chan_b))
    else $error("power-good stayed high with the ac sense flag folded in");

  a_pg_no_debounce: assert property (@(posedge mclk) disable iff (!rst_n)
    !cfg_q.pgDebounce |=> (pgFlagDeb == $past(rawFlag_q)))
    else $error("power-good path delayed with debounce off");

  a_threshold_set: assert property (@(posedge mclk) disable iff (!rst_n)
    (!thrZero && value_q[VW-1:VW-4] < cfg_q.threshold) |=> rawFlag_q)
    else $error("flag not raised below threshold");

  a_hyst_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (rawFlag_q && !thrZero && belowRel) |=> rawFlag_q)
    else $error("flag released inside the hysteresis band");

  a_thr_zero_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    thrZero |=> !rawFlag_q)
    else $error("flag set with a zero threshold");

  a_flag_no_debounce: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_q.debounceSel == ac_sense_pkg::DEB_NONE) |=> (flagDeb == $past(rawFlag_q)))
    else $error("flag delayed with debounce off");
endmodule : ac_sense_flag_logic

// ### dv/ac_sense_flag_logic_test.sv
`timescale 1ns/10ps
module ac_sense_flag_logic_test;
  localparam logic [15:0] TRIM = ac_sense_pkg::ADDR_GAIN_TRIM;
  localparam logic [15:0] CFG = ac_sense_pkg::ADDR_FLAG_CONFIG;
  localparam logic [15:0] STAT = ac_sense_pkg::ADDR_FLAG_STATUS;
  localparam int TICK = ac_sense_pkg::TICK_CYC;
  localparam int HYST = ac_sense_pkg::HYST_MV * 65536 / 1600;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic [15:0] acSample = 16'h0000;
  logic acSampleValid = 1'b0;
  logic pgRawA = 1'b1;
  logic pgRawB = 1'b1;
  logic [15:0] acSenseValue;
  logic acSenseFlag;
  logic pgA;
  logic pgB;
  logic rdSeen = 1'b0;
  logic [7:0] expQ[$];
  int num_errors = 0;
  int checked = 0;
  int seed = 32'hdd8cc2cc;

  // debounce limits kept small so the longest setting still fits a short run
  ac_sense_flag_logic #(.DEB_SHORT_TICKS(2), .DEB_MID_TICKS(3), .DEB_LONG_TICKS(4)) dut (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .acSample(acSample), .acSampleValid(acSampleValid), .powerGoodRawA(pgRawA),
    .powerGoodRawB(pgRawB), .acSenseValue(acSenseValue), .acSenseFlag(acSenseFlag),
    .power_good_chan_a(pgA), .power_good_chan_b(pgB));

  always #12.5 mclk = ~mclk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t mismatch: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr

  // the expected byte is queued as the strobe goes out
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge mclk);
    regRead <= 1'b0;
  endtask : rd

  // six idle cycles let value, raw compare, flag and power-good settle
  task automatic smp(input logic [15:0] v);
    @(posedge mclk);
    acSample <= v;
    acSampleValid <= 1'b1;
    @(posedge mclk);
    acSampleValid <= 1'b0;
    cyc(6);
  endtask : smp

  always @(posedge mclk) begin
    if (rdSeen && expQ.size() > 0) check(regRdata, expQ.pop_front());
    rdSeen <= regRead;
  end

  initial begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    conclude();
  end

  initial begin
    logic [15:0] s;
    logic [7:0] t;
    logic [3:0] th;
    logic b;
    int e;
    int k;
    cyc(6);
    rst_n <= 1'b1;
    rd(TRIM, ac_sense_pkg::GAIN_TRIM_RESET);
    rd(CFG, ac_sense_pkg::FLAG_CONFIG_RESET);
    rd(16'hfe80, 8'h00);
    for (int i = 0; i < 10; i++) begin
      t = (i < 2) ? {i[0], 7'h7f} : 8'($random(seed));
      s = 16'($random(seed));
      e = (int'(s) * int'(t[6:0])) >>> 10;
      e = t[7] ? int'(s) - e : int'(s) + e;
      if (e > 65535) e = 65535;
      wr(TRIM, t);
      rd(TRIM, t);
      smp(s);
      check(acSenseValue[15:8], e[15:8]);
      check(acSenseValue[7:0], e[7:0]);
      rd(ac_sense_pkg::ADDR_VALUE_HI, e[15:8]);
      rd(ac_sense_pkg::ADDR_VALUE_LO, e[7:0]);
    end
    wr(TRIM, 8'h00);
    for (int i = 0; i < 3; i++) begin
      th = (i == 0) ? 4'h1 : (i == 1) ? 4'h5 : 4'hf;
      wr(CFG, {2'b00, th, 2'b00});
      smp({th, 12'h000} - 16'h0001);
      rd(STAT, 8'h07);
      check({7'h00, acSenseFlag}, 8'h01);
      smp({th, 12'h000} + 16'(HYST - 1));
      rd(STAT, 8'h07);
      smp({th, 12'h000} + 16'(HYST));
      rd(STAT, 8'h00);
      check({6'h00, pgB, pgA}, 8'h03);
      smp({th, 12'h000});
      rd(STAT, 8'h00);
    end
    wr(CFG, 8'h04);
    smp(16'h0000);
    rd(STAT, 8'h07);
    wr(CFG, 8'h00);
    cyc(4);
    rd(STAT, 8'h00);
    check({7'h00, acSenseFlag}, 8'h00);
    wr(CFG, 8'h94);
    b = 1'($random(seed));
    pgRawB <= b;
    smp(16'h4fff);
    rd(STAT, 8'h07);
    check({6'h00, pgB, pgA}, 8'h00);
    smp(16'h5c00);
    check({6'h00, pgB, pgA}, {6'h00, b, 1'b1});
    pgRawB <= 1'b1;
    wr(CFG, 8'hd4);
    smp(16'h4fff);
    rd(STAT, 8'h03);
    cyc(TICK - 60);
    rd(STAT, 8'h03);
    check({6'h00, pgB, pgA}, 8'h03);
    cyc(TICK + 100);
    rd(STAT, 8'h07);
    check({6'h00, pgB, pgA}, 8'h00);
    smp(16'h5c00);
    rd(STAT, 8'h04);
    cyc(2 * TICK + 100);
    rd(STAT, 8'h00);
    for (int i = 0; i < 4; i++) begin
      k = (i == 2) ? 3 : (i == 1) ? 2 : 1;
      s = i[0] ? 16'h5c00 : 16'h4fff;
      wr(CFG, {2'b00, 4'h5, 2'(k)});
      if (i == 3) begin
        smp(s);
        cyc(TICK - 40);
        smp(16'h4fff);
      end
      smp(s);
      cyc(k * TICK - 60);
      rd(STAT, i[0] ? 8'h02 : 8'h05);
      cyc(TICK + 100);
      rd(STAT, i[0] ? 8'h00 : 8'h07);
    end
    cyc(4);
    conclude();
  end
endmodule : ac_sense_flag_logic_test
